// *** hw/ghp_defines.svh ***
// register indices, reset values, field positions and bus codes for the
// gpio hold / output / pull block; included by the controller and by the testbench
`ifndef GHP_DEFINES_SVH
`define GHP_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define GHP_IDX_HOLD_HI 32'h0b00_011a
`define GHP_IDX_OUT_LO 32'h0b00_011c
`define GHP_IDX_OUT_HI 32'h0b00_011e
`define GHP_IDX_PULL_USE 32'h0b00_02e0
`define GHP_IDX_PULL_DIR 32'h0b00_02e2
`define GHP_IDX_IRQ_EN 32'h0b00_0300
`define GHP_IDX_IRQ_STAT 32'h0b00_0302
`define GHP_IDX_TRIG 32'h0b00_0304
`define GHP_IDX_ACT_LVL 32'h0b00_0306
`define GHP_IDX_DIR_LO 32'h0b00_0308

`define GHP_RST_HOLD_HI 16'h0000
`define GHP_RST_OUT_LO 16'h0fff
`define GHP_RST_OUT_HI 16'h0000
`define GHP_RST_PULL 16'h0000
`define GHP_RST_CTRL 16'h0000

// writable bits; everything else is reserved and reads zero
`define GHP_MASK_ALL 16'hffff
`define GHP_MASK_OUT_HI 16'h0303
`define GHP_MASK_PULL 16'h7fff

`define GHP_BIT_LVL48 0
`define GHP_BIT_LVL49 1
`define GHP_BIT_EN48 8
`define GHP_BIT_EN49 9

`define GHP_RESP_OKAY 2'h0
`define GHP_RESP_SLVERR 2'h2

`define GHP_SYNC_STAGES 3

`endif

// *** hw/ghp_gpio_ctrl.sv ***
// gpio interrupt hold, upper output pins and lower pull control
// assumes an axi4-lite master on i_sys_clk and async pins 31..16
`timescale 1ns/10ps
`default_nettype none
`include "ghp_defines.svh"

module ghp_gpio_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_rtc_rst_n,
  input wire logic i_clk_en,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [15:0] i_irq_pin,
  output logic [15:0] o_irq_req,
  output logic o_irq_notify,
  output logic [15:0] o_pin_out_level_lo,
  output logic [1:0] o_pin_out_level_hi,
  output logic [1:0] o_pin_drive_en,
  output logic [14:0] o_pull_up_en,
  output logic [14:0] o_pull_down_en
);

  ghp_pkg::ghp_core_type st_q;
  ghp_pkg::ghp_core_type st_d;
  ghp_pkg::ghp_keep_type kp_q;
  ghp_pkg::ghp_keep_type kp_d;

  logic core_rst_n;
  logic [15:0] filt;
  logic [15:0] cond;
  logic [15:0] stat_view;
  logic [15:0] bmask;
  logic [15:0] clr;
  logic wr_go;
  ghp_pkg::ghp_reg_type wreg;
  ghp_pkg::ghp_reg_type rreg;

  // either reset clears the interrupt side
  assign core_rst_n = i_rst_n & i_rtc_rst_n;

  function automatic ghp_pkg::ghp_reg_type decode(input logic [31:0] a);
    case (a)
      (`GHP_IDX_HOLD_HI << 2): decode = ghp_pkg::GHP_REG_HOLD_HI;
      (`GHP_IDX_OUT_LO << 2): decode = ghp_pkg::GHP_REG_OUT_LO;
      (`GHP_IDX_OUT_HI << 2): decode = ghp_pkg::GHP_REG_OUT_HI;
      (`GHP_IDX_PULL_USE << 2): decode = ghp_pkg::GHP_REG_PULL_USE;
      (`GHP_IDX_PULL_DIR << 2): decode = ghp_pkg::GHP_REG_PULL_DIR;
      (`GHP_IDX_IRQ_EN << 2): decode = ghp_pkg::GHP_REG_IRQ_EN;
      (`GHP_IDX_IRQ_STAT << 2): decode = ghp_pkg::GHP_REG_IRQ_STAT;
      (`GHP_IDX_TRIG << 2): decode = ghp_pkg::GHP_REG_TRIG;
      (`GHP_IDX_ACT_LVL << 2): decode = ghp_pkg::GHP_REG_ACT_LVL;
      (`GHP_IDX_DIR_LO << 2): decode = ghp_pkg::GHP_REG_DIR_LO;
      default: decode = ghp_pkg::GHP_REG_NONE;
    endcase
  endfunction : decode

  // byte-lane merge that keeps reserved bits at zero
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [15:0] lanes,
    input logic [15:0] mask
  );
    logic [15:0] m;
    m = lanes & mask;
    merge16 = (old & ~m) | (data & m);
  endfunction : merge16

  ghp_pin_sync #(
    .WIDTH(16)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(core_rst_n),
    .i_clk_en(i_clk_en),
    .i_async(i_irq_pin),
    .o_level(filt)
  );

  // edge: any change; level: match against active level
  assign cond = (st_q.trig & (filt ^ st_q.prev)) |
                (~st_q.trig & ~(filt ^ st_q.act_lvl));
  // held pins show the latch, through pins the live condition
  assign stat_view = (st_q.latch & st_q.irq_latch_sel) |
                     (cond & ~st_q.irq_latch_sel);

  assign wr_go = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
  assign wreg = decode(st_q.aw_addr);
  assign rreg = decode(i_araddr);
  assign bmask = {{8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
  assign clr = (wr_go && wreg == ghp_pkg::GHP_REG_IRQ_STAT) ?
               (st_q.wdata[15:0] & bmask) : 16'h0000;

  // ready drops while frozen so no beat is taken and lost
  assign o_awready = i_clk_en & ~st_q.aw_got & ~st_q.bvalid;
  assign o_wready = i_clk_en & ~st_q.w_got & ~st_q.bvalid;
  assign o_arready = i_clk_en & ~st_q.rvalid;

  always_comb begin
    st_d = st_q;
    kp_d = kp_q;
    if (i_clk_en) begin
      st_d.prev = filt;
      // set wins over a same-cycle clear
      st_d.latch = (st_q.latch & ~clr) | (cond & st_q.irq_latch_sel);
      // through pins follow the pin, held pins the latch
      st_d.req = st_q.irq_enable_upper & stat_view;
      // pulls only while the lower direction is all input
      if (st_q.dir_select_lower == 16'h0000) begin
        kp_d.pull_up = kp_q.pull_use[14:0] & kp_q.pull_direction[14:0];
        kp_d.pull_down = kp_q.pull_use[14:0] & ~kp_q.pull_direction[14:0];
      end else begin
        kp_d.pull_up = 15'h0000;
        kp_d.pull_down = 15'h0000;
      end
      if (i_awvalid && o_awready) begin
        st_d.aw_got = 1'b1;
        st_d.aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        st_d.w_got = 1'b1;
        st_d.wdata = i_wdata;
        st_d.wstrb = i_wstrb;
      end
      if (wr_go) begin
        st_d.aw_got = 1'b0;
        st_d.w_got = 1'b0;
        st_d.bvalid = 1'b1;
        st_d.bresp = (wreg == ghp_pkg::GHP_REG_NONE) ?
                     `GHP_RESP_SLVERR : `GHP_RESP_OKAY;
        case (wreg)
          ghp_pkg::GHP_REG_HOLD_HI: begin
            st_d.irq_latch_sel = merge16(st_q.irq_latch_sel,
              st_q.wdata[15:0], bmask, `GHP_MASK_ALL);
          end
          // enable has its own storage, hold bits untouched
          ghp_pkg::GHP_REG_IRQ_EN: begin
            st_d.irq_enable_upper = merge16(st_q.irq_enable_upper,
              st_q.wdata[15:0], bmask, `GHP_MASK_ALL);
          end
          ghp_pkg::GHP_REG_TRIG: begin
            st_d.trig = merge16(st_q.trig, st_q.wdata[15:0], bmask,
              `GHP_MASK_ALL);
          end
          ghp_pkg::GHP_REG_ACT_LVL: begin
            st_d.act_lvl = merge16(st_q.act_lvl, st_q.wdata[15:0],
              bmask, `GHP_MASK_ALL);
          end
          ghp_pkg::GHP_REG_DIR_LO: begin
            st_d.dir_select_lower = merge16(st_q.dir_select_lower,
              st_q.wdata[15:0], bmask, `GHP_MASK_ALL);
          end
          ghp_pkg::GHP_REG_OUT_LO: begin
            kp_d.out_lo = merge16(kp_q.out_lo, st_q.wdata[15:0], bmask,
              `GHP_MASK_ALL);
          end
          ghp_pkg::GHP_REG_OUT_HI: begin
            kp_d.out_hi = merge16(kp_q.out_hi, st_q.wdata[15:0], bmask,
              `GHP_MASK_OUT_HI);
          end
          ghp_pkg::GHP_REG_PULL_USE: begin
            kp_d.pull_use = merge16(kp_q.pull_use, st_q.wdata[15:0],
              bmask, `GHP_MASK_PULL);
          end
          ghp_pkg::GHP_REG_PULL_DIR: begin
            kp_d.pull_direction = merge16(kp_q.pull_direction,
              st_q.wdata[15:0], bmask, `GHP_MASK_PULL);
          end
          default: begin
            st_d.bvalid = 1'b1;
          end
        endcase
      end
      if (st_q.bvalid && i_bready) begin
        st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && i_rready) begin
        st_d.rvalid = 1'b0;
      end
      if (i_arvalid && o_arready) begin
        st_d.rvalid = 1'b1;
        st_d.rresp = (rreg == ghp_pkg::GHP_REG_NONE) ?
                     `GHP_RESP_SLVERR : `GHP_RESP_OKAY;
        st_d.rdata = 32'h0000_0000;
        case (rreg)
          ghp_pkg::GHP_REG_HOLD_HI: st_d.rdata[15:0] = st_q.irq_latch_sel;
          ghp_pkg::GHP_REG_OUT_LO: st_d.rdata[15:0] = kp_q.out_lo;
          ghp_pkg::GHP_REG_OUT_HI: st_d.rdata[15:0] = kp_q.out_hi;
          ghp_pkg::GHP_REG_PULL_USE: st_d.rdata[15:0] = kp_q.pull_use;
          ghp_pkg::GHP_REG_PULL_DIR: begin
            st_d.rdata[15:0] = kp_q.pull_direction;
          end
          ghp_pkg::GHP_REG_IRQ_EN: begin
            st_d.rdata[15:0] = st_q.irq_enable_upper;
          end
          ghp_pkg::GHP_REG_IRQ_STAT: st_d.rdata[15:0] = stat_view;
          ghp_pkg::GHP_REG_TRIG: st_d.rdata[15:0] = st_q.trig;
          ghp_pkg::GHP_REG_ACT_LVL: st_d.rdata[15:0] = st_q.act_lvl;
          ghp_pkg::GHP_REG_DIR_LO: begin
            st_d.rdata[15:0] = st_q.dir_select_lower;
          end
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // hold bits clear on every reset kind
  always_ff @(posedge i_sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st_q <= '0;
      st_q.irq_latch_sel <= `GHP_RST_HOLD_HI;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs and pulls survive other resets
  always_ff @(posedge i_sys_clk or negedge i_rtc_rst_n) begin
    if (!i_rtc_rst_n) begin
      kp_q <= '0;
      kp_q.out_lo <= `GHP_RST_OUT_LO;
      kp_q.out_hi <= `GHP_RST_OUT_HI;
      kp_q.pull_use <= `GHP_RST_PULL;
      kp_q.pull_direction <= `GHP_RST_PULL;
    end else begin
      kp_q <= kp_d;
    end
  end

  assign o_bvalid = st_q.bvalid;
  assign o_bresp = st_q.bresp;
  assign o_rvalid = st_q.rvalid;
  assign o_rdata = st_q.rdata;
  assign o_rresp = st_q.rresp;
  assign o_irq_req = st_q.req;
  assign o_irq_notify = |st_q.req;
  // shared pins: debug port, key scan, bus width select
  assign o_pin_out_level_lo = kp_q.out_lo;
  assign o_pin_out_level_hi = {kp_q.out_hi[`GHP_BIT_LVL49],
                               kp_q.out_hi[`GHP_BIT_LVL48]};
  // pin 49 stays an input through the rtc reset
  assign o_pin_drive_en = {kp_q.out_hi[`GHP_BIT_EN49] & i_rtc_rst_n,
                           kp_q.out_hi[`GHP_BIT_EN48]};
  assign o_pull_up_en = kp_q.pull_up;
  assign o_pull_down_en = kp_q.pull_down;

  a_hold_capture: assert property (
    @(posedge i_sys_clk) disable iff (!core_rst_n)
    (i_clk_en && (cond & st_q.irq_latch_sel) != 16'h0000) |=>
    ((st_q.latch & $past(cond & st_q.irq_latch_sel)) ==
     $past(cond & st_q.irq_latch_sel)))
    else $error("held request not latched");

  a_latch_clear_w1c: assert property (
    @(posedge i_sys_clk) disable iff (!core_rst_n)
    ((~st_q.latch & $past(st_q.latch)) != 16'h0000) |->
    ($past(clr) != 16'h0000))
    else $error("latch dropped without status write");

  a_hold_en_indep: assert property (
    @(posedge i_sys_clk) disable iff (!core_rst_n)
    (wr_go && wreg == ghp_pkg::GHP_REG_IRQ_EN) |=>
    $stable(st_q.irq_latch_sel))
    else $error("enable write changed hold bits");

  a_through_live: assert property (
    @(posedge i_sys_clk) disable iff (!core_rst_n)
    i_clk_en |=> ((st_q.req & ~$past(st_q.irq_latch_sel)) ==
    $past(cond & st_q.irq_enable_upper & ~st_q.irq_latch_sel)))
    else $error("through request not live");

  a_masked_silent: assert property (
    @(posedge i_sys_clk) disable iff (!core_rst_n)
    ##1 ((st_q.req & ~$past(st_q.irq_enable_upper)) == 16'h0000))
    else $error("masked pin notified");

  a_pin49_input: assert property (
    @(posedge i_sys_clk) !i_rtc_rst_n |-> !o_pin_drive_en[1])
    else $error("pin 49 driven during rtc reset");

  a_pull_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_rtc_rst_n || !core_rst_n)
    (i_clk_en && st_q.dir_select_lower != 16'h0000) |=>
    (o_pull_up_en == 15'h0000 && o_pull_down_en == 15'h0000))
    else $error("pull active with outputs selected");

  a_reserved_zero: assert property (
    @(posedge i_sys_clk) disable iff (!core_rst_n)
    o_rvalid |-> (o_rdata[31:16] == 16'h0000 &&
    kp_q.pull_use[15] == 1'b0 && (kp_q.out_hi & ~`GHP_MASK_OUT_HI) ==
    16'h0000))
    else $error("reserved bit nonzero");

  a_pull_select: assert property (
    @(posedge i_sys_clk) disable iff (!i_rtc_rst_n)
    (i_clk_en && st_q.dir_select_lower == 16'h0000) |=>
    (o_pull_up_en ==
     $past(kp_q.pull_use[14:0] & kp_q.pull_direction[14:0]) &&
     o_pull_down_en ==
     $past(kp_q.pull_use[14:0] & ~kp_q.pull_direction[14:0])))
    else $error("pull select mismatch");

  a_pull_pin15: assert property (
    @(posedge i_sys_clk) disable iff (!i_rtc_rst_n)
    (kp_q.pull_use[15] == 1'b0 && kp_q.pull_direction[15] == 1'b0))
    else $error("pin 15 pull bit set");

  // second low sample so the keep flops have surely seen the reset
  a_rtc_out_reset: assert property (
    @(posedge i_sys_clk) (!i_rtc_rst_n && $past(!i_rtc_rst_n)) |->
    (o_pin_out_level_lo == `GHP_RST_OUT_LO && o_pull_up_en == 15'h0000))
    else $error("outputs not reset by rtc reset");

endmodule : ghp_gpio_ctrl
`default_nettype wire

// *** hw/ghp_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to i_sys_clk
`timescale 1ns/10ps
`default_nettype none
module ghp_pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } ghp_sync_type;

  ghp_sync_type st_q;
  ghp_sync_type st_d;

  always_comb begin
    st_d = st_q;
    if (i_clk_en) begin
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // one transition yields one filtered change
      for (int i = 0; i < WIDTH; i++) begin
        if (st_q.s2[i] == st_q.s3[i]) begin
          st_d.lvl[i] = st_q.s3[i];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.lvl;

endmodule : ghp_pin_sync
`default_nettype wire

// *** hw/ghp_pkg.sv ***
// types shared by the gpio hold / output / pull block
// assumes nothing beyond a SystemVerilog compiler
package ghp_pkg;

  typedef enum logic [3:0] {
    GHP_REG_NONE = 4'h0,
    GHP_REG_HOLD_HI = 4'h1,
    GHP_REG_OUT_LO = 4'h2,
    GHP_REG_OUT_HI = 4'h3,
    GHP_REG_PULL_USE = 4'h4,
    GHP_REG_PULL_DIR = 4'h5,
    GHP_REG_IRQ_EN = 4'h6,
    GHP_REG_IRQ_STAT = 4'h7,
    GHP_REG_TRIG = 4'h8,
    GHP_REG_ACT_LVL = 4'h9,
    GHP_REG_DIR_LO = 4'ha
  } ghp_reg_type;

  // state cleared by any reset
  typedef struct packed {
    logic [15:0] irq_latch_sel;
    logic [15:0] irq_enable_upper;
    logic [15:0] trig;
    logic [15:0] act_lvl;
    logic [15:0] dir_select_lower;
    logic [15:0] latch;
    logic [15:0] prev;
    logic [15:0] req;
    logic aw_got;
    logic w_got;
    logic [31:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ghp_core_type;

  // state cleared only by the rtc-domain reset
  typedef struct packed {
    logic [15:0] out_lo;
    logic [15:0] out_hi;
    logic [15:0] pull_use;
    logic [15:0] pull_direction;
    logic [14:0] pull_up;
    logic [14:0] pull_down;
  } ghp_keep_type;

endpackage : ghp_pkg

// *** verification/ghp_pin_model.sv ***
// pin-side partner: drives gpio pins 31..16 off the bus clock grid
// assumes the bench commands each level and the reply speed
`timescale 1ns/10ps
`default_nettype none
module ghp_pin_model (
  input wire logic [15:0] i_level,
  input wire logic i_slow,
  output logic [15:0] o_pin
);
  initial o_pin = 16'h0000;
  // odd delays keep pin edges away from clock edges
  always @(i_level) begin
    if (i_slow) o_pin <= #61.3 i_level;
    else o_pin <= #3.7 i_level;
  end
endmodule : ghp_pin_model
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the gpio hold / output / pull block
// assumes ghp_defines.svh on the include path; axi4-lite master here
`timescale 1ns/10ps
`default_nettype none
`include "ghp_defines.svh"
module testbench;
  logic clk, rst_n, rtc_n, awv, wv, bready, arv, rready, slow, aw_rdy;
  logic w_rdy, bv, ar_rdy, rv, notify;
  logic [31:0] awaddr, wdata, araddr, rdata, rnd;
  logic [15:0] lvl, pin, irq, out_lo;
  logic [1:0] bresp, rresp, lvl_hi, drv_en;
  logic [14:0] pu, pd;
  logic cen;
  logic [3:0] strb;
  logic [33:0] exp_q[$];
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 18016;

  ghp_gpio_ctrl u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_rtc_rst_n(rtc_n), .i_clk_en(cen),
    .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(aw_rdy),
    .i_wdata(wdata), .i_wstrb(strb), .i_wvalid(wv), .o_wready(w_rdy),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arv), .o_arready(ar_rdy),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rready),
    .i_irq_pin(pin), .o_irq_req(irq), .o_irq_notify(notify),
    .o_pin_out_level_lo(out_lo), .o_pin_out_level_hi(lvl_hi),
    .o_pin_drive_en(drv_en), .o_pull_up_en(pu), .o_pull_down_en(pd)
  );

  ghp_pin_model u_pins (.i_level(lvl), .i_slow(slow), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(input string nm, input logic [33:0] seen, input logic [33:0] ex);
    total_checks++;
    if (seen !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task complete_run;
    $display("mismatches %0d of %0d checks", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // result watcher: oldest note is the expected answer
  always @(posedge clk) begin
    cycles++;
    if (rv && rready) check("rdata", {rresp, rdata}, exp_q.pop_front());
    if (bv && bready) check("bresp", {bresp, 32'h0}, exp_q.pop_front());
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic wr(input logic [31:0] idx, input logic [15:0] d,
                    input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge clk);
    awaddr <= idx << 2;
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && aw_rdy) awv <= 1'b0;
      if (wv && w_rdy) wv <= 1'b0;
    end while (!(bv && bready));
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] idx, input logic [15:0] d,
                    input logic [1:0] r);
    exp_q.push_back({r, 16'h0000, d});
    @(posedge clk);
    araddr <= idx << 2;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && ar_rdy) arv <= 1'b0;
    end while (!(rv && rready));
    rready <= 1'b0;
  endtask : rd

  // pin path has a synchroniser, so give it a generous settle
  task irq_is(input logic [15:0] e);
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("irq", {notify, irq}, {|e, e});
  endtask : irq_is

  initial begin
    rst_n = 1'b0;
    rtc_n = 1'b0;
    {awv, wv, bready, arv, rready, slow} = 6'h00;
    cen = 1'b1;
    strb = 4'hf;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    lvl = 16'h0000;
    rnd = $random(seed);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rtc_n <= 1'b1;
    rd(`GHP_IDX_HOLD_HI, `GHP_RST_HOLD_HI, `GHP_RESP_OKAY);
    rd(`GHP_IDX_OUT_LO, `GHP_RST_OUT_LO, `GHP_RESP_OKAY);
    rd(`GHP_IDX_OUT_HI, `GHP_RST_OUT_HI, `GHP_RESP_OKAY);
    rd(`GHP_IDX_PULL_USE, `GHP_RST_PULL, `GHP_RESP_OKAY);
    rd(`GHP_IDX_PULL_DIR, `GHP_RST_PULL, `GHP_RESP_OKAY);
    check("out_reset", {out_lo, drv_en}, {16'h0fff, 2'b00});
    wr(`GHP_IDX_OUT_LO, rnd[15:0], `GHP_RESP_OKAY);
    rd(`GHP_IDX_OUT_LO, rnd[15:0], `GHP_RESP_OKAY);
    // only the low lane is strobed, so the upper byte must survive
    strb <= 4'h1;
    wr(`GHP_IDX_OUT_LO, {~rnd[15:8], rnd[7:0]}, `GHP_RESP_OKAY);
    strb <= 4'hf;
    rd(`GHP_IDX_OUT_LO, rnd[15:0], `GHP_RESP_OKAY);
    wr(`GHP_IDX_OUT_HI, 16'hfffe, `GHP_RESP_OKAY);
    rd(`GHP_IDX_OUT_HI, 16'h0302, `GHP_RESP_OKAY);
    check("lvl", {lvl_hi, drv_en, out_lo}, {4'b1011, rnd[15:0]});
    wr(`GHP_IDX_OUT_HI, 16'h0201, `GHP_RESP_OKAY);
    @(negedge clk);
    check("pin48_49", {lvl_hi, drv_en}, 4'b0110);
    wr(`GHP_IDX_DIR_LO, 16'h0000, `GHP_RESP_OKAY);
    wr(`GHP_IDX_PULL_USE, 16'hffff, `GHP_RESP_OKAY);
    rd(`GHP_IDX_PULL_USE, 16'h7fff, `GHP_RESP_OKAY);
    wr(`GHP_IDX_PULL_DIR, 16'h80f0, `GHP_RESP_OKAY);
    rd(`GHP_IDX_PULL_DIR, 16'h00f0, `GHP_RESP_OKAY);
    check("pulls", {pu, pd}, {15'h00f0, 15'h7f0f});
    wr(`GHP_IDX_PULL_USE, 16'h00ff, `GHP_RESP_OKAY);
    @(negedge clk);
    check("pull_use", {pu, pd}, {15'h00f0, 15'h000f});
    wr(`GHP_IDX_DIR_LO, 16'h0001, `GHP_RESP_OKAY);
    @(negedge clk);
    check("pull_dir", {pu, pd}, 30'h0);
    rd(`GHP_IDX_DIR_LO, 16'h0001, `GHP_RESP_OKAY);
    wr(`GHP_IDX_HOLD_HI, 16'hffff, `GHP_RESP_OKAY);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`GHP_IDX_HOLD_HI, 16'h0000, `GHP_RESP_OKAY);
    rd(`GHP_IDX_OUT_LO, rnd[15:0], `GHP_RESP_OKAY);
    rd(`GHP_IDX_PULL_DIR, 16'h00f0, `GHP_RESP_OKAY);
    rd(32'h0b00_0200, 16'h0000, `GHP_RESP_SLVERR);
    wr(32'h0b00_0200, 16'hffff, `GHP_RESP_SLVERR);
    // held edge request on pin 16, masked first
    wr(`GHP_IDX_TRIG, 16'h0001, `GHP_RESP_OKAY);
    wr(`GHP_IDX_HOLD_HI, 16'h0001, `GHP_RESP_OKAY);
    lvl <= 16'h0001;
    irq_is(16'h0000);
    wr(`GHP_IDX_IRQ_EN, 16'h0001, `GHP_RESP_OKAY);
    irq_is(16'h0001);
    // frozen block: readies low, held request stands
    @(posedge clk);
    cen <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("freeze", {aw_rdy, w_rdy, ar_rdy, irq}, 19'h0_0001);
    @(posedge clk);
    cen <= 1'b1;
    rd(`GHP_IDX_HOLD_HI, 16'h0001, `GHP_RESP_OKAY);
    rd(`GHP_IDX_IRQ_EN, 16'h0001, `GHP_RESP_OKAY);
    rd(`GHP_IDX_TRIG, 16'h0001, `GHP_RESP_OKAY);
    // pin 16 held; other pins low meet the active-low level condition
    rd(`GHP_IDX_IRQ_STAT, 16'hffff, `GHP_RESP_OKAY);
    wr(`GHP_IDX_IRQ_STAT, 16'h0001, `GHP_RESP_OKAY);
    irq_is(16'h0000);
    slow <= 1'b1;
    lvl <= 16'h0000;
    irq_is(16'h0001);
    wr(`GHP_IDX_IRQ_STAT, 16'h0001, `GHP_RESP_OKAY);
    // level trigger set before pass-through goes unmasked
    wr(`GHP_IDX_TRIG, 16'h0000, `GHP_RESP_OKAY);
    wr(`GHP_IDX_ACT_LVL, 16'h0002, `GHP_RESP_OKAY);
    rd(`GHP_IDX_ACT_LVL, 16'h0002, `GHP_RESP_OKAY);
    wr(`GHP_IDX_HOLD_HI, 16'h0000, `GHP_RESP_OKAY);
    wr(`GHP_IDX_IRQ_EN, 16'h0002, `GHP_RESP_OKAY);
    lvl <= 16'h0002;
    irq_is(16'h0002);
    lvl <= 16'h0000;
    irq_is(16'h0000);
    wr(`GHP_IDX_IRQ_EN, 16'h0000, `GHP_RESP_OKAY);
    lvl <= 16'h0002;
    irq_is(16'h0000);
    lvl <= 16'h0000;
    repeat (12) @(posedge clk);
    wr(`GHP_IDX_IRQ_EN, 16'h0002, `GHP_RESP_OKAY);
    irq_is(16'h0000);
    @(posedge clk);
    rtc_n <= 1'b0;
    @(negedge clk);
    check("rtc_reset", {out_lo, drv_en, pu}, {16'h0fff, 17'h0});
    @(posedge clk);
    rtc_n <= 1'b1;
    rd(`GHP_IDX_PULL_USE, 16'h0000, `GHP_RESP_OKAY);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
